// File: core/sbai_dram.sv
// Operation
// - Sample inputs and launch reads on rising edge
// - Row must be open before column access
// - Bank select plus twelve-bit row address
// - Column command address gives burst start
// - Burst continues with internal column stepping
// - Burst length 1, 2, 4, 8 or page
// - Read latency two or three cycles
// - Auto precharge closes row after burst
// - Banks independent; precharge one during other bursts
// - New column command accepted every cycle
// - Burst stop or precharge ends burst
// - Burst reads with single-location writes mode
// - Controller issues 4096 refreshes per 64 ms
// - Partial array and four self-refresh periods
// - Separate low and high byte masks
// - Mask blocks write, tristates read byte
// - Chip select high ignores commands
// - Precharge address bit ten closes all banks
// - Clock enable low ignores the edge unless it enters self-refresh
module sbai_dram #(
   parameter int MEM_AW = 8
) (
   input wire logic clk,
   input wire logic arst_n,
   sbai_link_if.mem link
);
   localparam int WORDS = 2 ** MEM_AW;
   localparam int BW = sbai_pkg::BA_W;
   localparam int AW = sbai_pkg::ADDR_W;
   localparam int CW = sbai_pkg::COL_W;
   localparam int DW = sbai_pkg::DQ_W;
   localparam int NB = sbai_pkg::BANKS;

   logic [2:0] bl_q, bl_d;
   logic il_q, il_d;
   logic cl3_q, cl3_d;
   logic sw_q, sw_d;
   logic [2:0] pasr_q, pasr_d;
   logic [1:0] tcsr_q, tcsr_d;
   logic [NB-1:0] open_q, open_d;
   logic [NB-1:0] ok_q, ok_d;
   logic [AW-1:0] row_q [NB];
   logic [AW-1:0] row_d [NB];
   logic bact_q, bact_d;
   logic bwr_q, bwr_d;
   logic bap_q, bap_d;
   logic bpage_q, bpage_d;
   logic [BW-1:0] bbank_q, bbank_d;
   logic [CW-1:0] bstart_q, bstart_d;
   logic [CW-1:0] bcnt_q, bcnt_d;
   logic [CW:0] blen_q, blen_d;
   logic [2:0] pv_q, pv_d;
   logic [DW-1:0] pd_q [3];
   logic [DW-1:0] pd_d [3];
   logic [1:0] pm_q [2];
   logic [1:0] pm_d [2];
   logic sr_q, sr_d;
   logic [7:0] srt_q, srt_d;
   logic [DW-1:0] mem_q [WORDS];
   logic [DW-1:0] mem_d [WORDS];

   logic [2:0] cmd;
   logic [BW-1:0] ba;
   logic [AW-1:0] addr;
   logic live;
   logic sel;
   logic is_rw;
   logic stop;
   logic beat_go;
   logic beat_wr;
   logic [BW-1:0] beat_ba;
   logic [CW-1:0] beat_col;
   logic [MEM_AW-1:0] beat_idx;
   logic [CW:0] beats;

   // Column for a beat: wraps inside the burst-length aligned block.
   function automatic logic [CW-1:0] col_at(input logic [CW-1:0] s,
      input logic [CW-1:0] c, input logic [CW-1:0] m, input logic il);
      logic [CW-1:0] step;
      step = il ? (s ^ c) : CW'(s + c);
      return (s & ~m) | (step & m);
   endfunction

   // Storage is a window of the array; rows beyond it alias.
   function automatic logic [MEM_AW-1:0] mem_idx(input logic [BW-1:0] b,
      input logic [AW-1:0] r, input logic [CW-1:0] c);
      logic [BW+AW+CW-1:0] full;
      full = {b, r, c};
      return full[MEM_AW-1:0];
   endfunction

   // Banks that keep their contents under partial-array self-refresh.
   function automatic logic keeps(input logic [2:0] p, input int b);
      case (p)
         sbai_pkg::PASR_HALF: return b < 2;
         sbai_pkg::PASR_QUART: return b == 0;
         default: return 1'b1;
      endcase
   endfunction

   // Command decode; the whole edge is void while clock enable is low, unless it enters self-refresh.
   assign cmd = {link.ras_n, link.cas_n, link.we_n};
   assign ba = link.bank_select;
   assign addr = link.row_col_address;
   assign live = link.cke && !sr_q;
   assign sel = live && !link.cs_n;
   assign is_rw = sel && (cmd == sbai_pkg::C_RD || cmd == sbai_pkg::C_WR)
                  && open_q[ba];
   assign stop = sel && (cmd == sbai_pkg::C_BST ||
                 (cmd == sbai_pkg::C_PRE &&
                  (addr[sbai_pkg::AP_BIT] || ba == bbank_q)));
   assign beats = (cmd == sbai_pkg::C_WR && sw_q) ? 10'h001 :
                  sbai_pkg::bl_beats(bl_q);

   // Beat of this edge: a new column command overrides a running burst.
   always_comb begin
      if (is_rw) begin
         beat_go = 1'b1;
         beat_wr = cmd == sbai_pkg::C_WR;
         beat_ba = ba;
         beat_col = addr[CW-1:0];
      end else begin
         beat_go = live && bact_q && !stop;
         beat_wr = bwr_q;
         beat_ba = bbank_q;
         beat_col = col_at(bstart_q, bcnt_q, CW'(blen_q - 10'h001),
                           il_q && !bpage_q);
      end
      beat_idx = mem_idx(beat_ba, row_q[beat_ba], beat_col);
   end

   // Next state of rows, burst engine, mode, read pipe and storage.
   always_comb begin
      bl_d = bl_q;
      il_d = il_q;
      cl3_d = cl3_q;
      sw_d = sw_q;
      pasr_d = pasr_q;
      tcsr_d = tcsr_q;
      open_d = open_q;
      ok_d = ok_q;
      row_d = row_q;
      bact_d = bact_q;
      bwr_d = bwr_q;
      bap_d = bap_q;
      bpage_d = bpage_q;
      bbank_d = bbank_q;
      bstart_d = bstart_q;
      bcnt_d = bcnt_q;
      blen_d = blen_q;
      pv_d = pv_q;
      pd_d = pd_q;
      pm_d = pm_q;
      sr_d = sr_q;
      srt_d = 8'h00;
      mem_d = mem_q;
      if (live) begin
         pv_d = {pv_q[1:0], beat_go && !beat_wr};
         pd_d[0] = ok_q[beat_ba] ? mem_q[beat_idx] : '0;
         pd_d[1] = pd_q[0];
         pd_d[2] = pd_q[1];
         pm_d[0] = {link.high_byte_mask, link.low_byte_mask};
         pm_d[1] = pm_q[0];
         if (beat_go && beat_wr) begin
            // Masked bytes keep their stored value.
            if (!link.low_byte_mask) begin
               mem_d[beat_idx][7:0] = link.dq[7:0];
            end
            if (!link.high_byte_mask) begin
               mem_d[beat_idx][15:8] = link.dq[15:8];
            end
            ok_d[beat_ba] = 1'b1;
         end
         if (is_rw) begin
            bwr_d = cmd == sbai_pkg::C_WR;
            bbank_d = ba;
            bstart_d = addr[CW-1:0];
            bcnt_d = 9'h001;
            blen_d = beats;
            bpage_d = beats == sbai_pkg::PAGE_BEATS;
            bap_d = addr[sbai_pkg::AP_BIT];
            bact_d = beats != 10'h001;
            if (beats == 10'h001 && addr[sbai_pkg::AP_BIT]) begin
               open_d[ba] = 1'b0;
            end
         end else if (bact_q) begin
            if (stop) begin
               bact_d = 1'b0;
            end else begin
               bcnt_d = bcnt_q + 9'h001;
               if (!bpage_q && {1'b0, bcnt_d} == blen_q) begin
                  bact_d = 1'b0;
                  if (bap_q) begin
                     open_d[bbank_q] = 1'b0;
                  end
               end
            end
         end
         if (sel) begin
            case (cmd)
               sbai_pkg::C_ACT: begin
                  open_d[ba] = 1'b1;
                  row_d[ba] = addr;
               end
               sbai_pkg::C_PRE: begin
                  if (addr[sbai_pkg::AP_BIT]) begin
                     open_d = '0;
                  end else begin
                     open_d[ba] = 1'b0;
                  end
               end
               sbai_pkg::C_LMR: begin
                  if (ba == '0) begin
                     bl_d = addr[sbai_pkg::MR_BL_LSB +: 3];
                     il_d = addr[sbai_pkg::MR_IL_BIT];
                     cl3_d = addr[sbai_pkg::MR_CL_LSB +: 3] == sbai_pkg::CL_3;
                     sw_d = addr[sbai_pkg::MR_SW_BIT];
                  end else if (ba == sbai_pkg::EMR_BA) begin
                     pasr_d = addr[sbai_pkg::EMR_PASR_LSB +: 3];
                     tcsr_d = addr[sbai_pkg::EMR_TCSR_LSB +: 2];
                  end
               end
               default: begin
               end
            endcase
         end
      end
      // Self-refresh: banks outside the kept part lose data at each tick.
      if (!sr_q && !link.cke && !link.cs_n && cmd == sbai_pkg::C_REF) begin
         sr_d = 1'b1;
      end else if (sr_q && link.cke) begin
         sr_d = 1'b0;
      end
      if (sr_q) begin
         if (srt_q >= sbai_pkg::SR_PER[tcsr_q] - 8'h01) begin
            for (int b = 0; b < NB; b++) begin
               ok_d[b] = ok_q[b] && keeps(pasr_q, b);
            end
         end else begin
            srt_d = srt_q + 8'h01;
         end
      end
   end

   // All state registers; storage clears so reads are defined.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         bl_q <= sbai_pkg::BL_1;
         il_q <= 1'b0;
         cl3_q <= 1'b1;
         sw_q <= 1'b0;
         pasr_q <= 3'h0;
         tcsr_q <= 2'h0;
         open_q <= '0;
         ok_q <= '1;
         row_q <= '{default: '0};
         bact_q <= 1'b0;
         bwr_q <= 1'b0;
         bap_q <= 1'b0;
         bpage_q <= 1'b0;
         bbank_q <= '0;
         bstart_q <= '0;
         bcnt_q <= '0;
         blen_q <= '0;
         pv_q <= '0;
         pd_q <= '{default: '0};
         pm_q <= '{default: 2'h3};
         sr_q <= 1'b0;
         srt_q <= 8'h00;
         mem_q <= '{default: '0};
      end else begin
         bl_q <= bl_d;
         il_q <= il_d;
         cl3_q <= cl3_d;
         sw_q <= sw_d;
         pasr_q <= pasr_d;
         tcsr_q <= tcsr_d;
         open_q <= open_d;
         ok_q <= ok_d;
         row_q <= row_d;
         bact_q <= bact_d;
         bwr_q <= bwr_d;
         bap_q <= bap_d;
         bpage_q <= bpage_d;
         bbank_q <= bbank_d;
         bstart_q <= bstart_d;
         bcnt_q <= bcnt_d;
         blen_q <= blen_d;
         pv_q <= pv_d;
         pd_q <= pd_d;
         pm_q <= pm_d;
         sr_q <= sr_d;
         srt_q <= srt_d;
         mem_q <= mem_d;
      end
   end

   // Read data leaves the pipe two or three edges after its command.
   assign link.mem_dq = cl3_q ? pd_q[2] : pd_q[1];
   for (genvar l = 0; l < 2; l++) begin : g_oe
      assign link.mem_dq_oe[l] = (cl3_q ? pv_q[2] : pv_q[1]) &&
                                 !pm_q[1][l];
   end
endmodule

// File: core/sbai_pkg.sv
package sbai_pkg;
   // Array geometry of the sixteen-bit organisation.
   localparam int BANKS = 4;
   localparam int BA_W = 2;
   localparam int ADDR_W = 12;
   localparam int COL_W = 9;
   localparam int DQ_W = 16;
   localparam int AP_BIT = 10;
   localparam int CLK_NS = 4;

   // Command codes on {ras_n, cas_n, we_n} with chip select low.
   localparam logic [2:0] C_LMR = 3'h0;
   localparam logic [2:0] C_REF = 3'h1;
   localparam logic [2:0] C_PRE = 3'h2;
   localparam logic [2:0] C_ACT = 3'h3;
   localparam logic [2:0] C_WR = 3'h4;
   localparam logic [2:0] C_RD = 3'h5;
   localparam logic [2:0] C_BST = 3'h6;
   localparam logic [2:0] C_NOP = 3'h7;

   // Mode and extended mode register fields, taken from the address.
   localparam int MR_BL_LSB = 0;
   localparam int MR_IL_BIT = 3;
   localparam int MR_CL_LSB = 4;
   localparam int MR_SW_BIT = 9;
   localparam logic [2:0] BL_1 = 3'h0;
   localparam logic [2:0] BL_2 = 3'h1;
   localparam logic [2:0] BL_4 = 3'h2;
   localparam logic [2:0] BL_8 = 3'h3;
   localparam logic [2:0] BL_PAGE = 3'h7;
   localparam logic [2:0] CL_3 = 3'h3;
   localparam logic [1:0] LAT2 = 2'h2;
   localparam logic [1:0] LAT3 = 2'h3;
   localparam logic [1:0] EMR_BA = 2'h2;
   localparam int EMR_PASR_LSB = 0;
   localparam int EMR_TCSR_LSB = 3;
   localparam logic [2:0] PASR_HALF = 3'h1;
   localparam logic [2:0] PASR_QUART = 3'h2;
   localparam logic [COL_W:0] PAGE_BEATS = 10'h200;

   // Self-refresh tick period in cycles for each of the four settings.
   localparam logic [7:0] SR_PER [4] = '{8'h10, 8'h20, 8'h40, 8'h80};

   // Refresh obligation: 4096 refreshes in every 64 ms.
   localparam int REF_WIN_MS = 64;
   localparam int REF_CNT = 4096;
   localparam int REF_IVL_NS = REF_WIN_MS * 1000000 / REF_CNT;
   localparam int REF_IVL_CYC = REF_IVL_NS / CLK_NS;

   // Controller register map and fields.
   localparam int APB_AW = 8;
   localparam logic [7:0] A_CMD = 8'h00;
   localparam logic [7:0] A_WDATA = 8'h04;
   localparam logic [7:0] A_RDATA = 8'h08;
   localparam logic [7:0] A_STAT = 8'h0c;
   localparam logic [7:0] A_CFG = 8'h10;
   localparam int F_OP_LSB = 0;
   localparam int F_BA_LSB = 3;
   localparam int F_AD_LSB = 5;
   localparam int F_ML_BIT = 16;
   localparam int F_MH_BIT = 17;
   localparam int S_BUSY = 0;
   localparam int S_RDONE = 1;
   localparam int S_REFUSED = 2;
   localparam int G_REFEN = 0;
   localparam int G_CKE = 1;

   typedef enum logic [2:0] {
      CS_IDLE, CS_CMD, CS_WR, CS_RD, CS_PRE, CS_REF
   } sbai_cst_e;

   // Number of beats for a burst length code; unknown codes act as one.
   function automatic logic [COL_W:0] bl_beats(input logic [2:0] code);
      case (code)
         BL_2: return 10'h002;
         BL_4: return 10'h004;
         BL_8: return 10'h008;
         BL_PAGE: return PAGE_BEATS;
         default: return 10'h001;
      endcase
   endfunction
endpackage

// File: core/sbai_link_if.sv
interface sbai_link_if;
   logic cke;
   logic cs_n;
   logic ras_n;
   logic cas_n;
   logic we_n;
   logic [sbai_pkg::BA_W-1:0] bank_select;
   logic [sbai_pkg::ADDR_W-1:0] row_col_address;
   logic low_byte_mask;
   logic high_byte_mask;
   logic [sbai_pkg::DQ_W-1:0] ctl_dq;
   logic ctl_dq_oe;
   logic [sbai_pkg::DQ_W-1:0] mem_dq;
   logic [1:0] mem_dq_oe;
   logic [sbai_pkg::DQ_W-1:0] dq;

   // Each byte lane resolves on its own; an undriven lane reads as zero.
   for (genvar l = 0; l < 2; l++) begin : g_lane
      assign dq[l*8 +: 8] = mem_dq_oe[l] ? mem_dq[l*8 +: 8] :
                            ctl_dq_oe ? ctl_dq[l*8 +: 8] : 8'h00;
   end

   modport ctrl (
      output cke, cs_n, ras_n, cas_n, we_n, bank_select, row_col_address,
      output low_byte_mask, high_byte_mask, ctl_dq, ctl_dq_oe,
      input dq
   );
   modport mem (
      input cke, cs_n, ras_n, cas_n, we_n, bank_select, row_col_address,
      input low_byte_mask, high_byte_mask, dq,
      output mem_dq, mem_dq_oe
   );
endinterface

// File: core/sbai_ctrl.sv
module sbai_ctrl (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [sbai_pkg::APB_AW-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   sbai_link_if.ctrl link
);
   localparam int AW = sbai_pkg::ADDR_W;
   localparam int DW = sbai_pkg::DQ_W;

   sbai_pkg::sbai_cst_e st_q, st_d;
   logic cs_n_q, cs_n_d;
   logic [2:0] cmd_q, cmd_d;
   logic [sbai_pkg::BA_W-1:0] ba_q, ba_d;
   logic [AW-1:0] addr_q, addr_d;
   logic [DW-1:0] dq_q, dq_d;
   logic oe_q, oe_d;
   logic [1:0] mask_q, mask_d;
   logic [17:0] wdata_q, wdata_d;
   logic [DW-1:0] rdata_q, rdata_d;
   logic rdone_q, rdone_d;
   logic refused_q, refused_d;
   logic refen_q, refen_d;
   logic cke_q, cke_d;
   logic [2:0] bl_q, bl_d;
   logic sw_q, sw_d;
   logic cl3_q, cl3_d;
   logic [sbai_pkg::COL_W:0] left_q, left_d;
   logic [1:0] cnt_q, cnt_d;
   logic [11:0] tmr_q, tmr_d;
   logic due_q, due_d;

   logic wacc;
   logic issue;
   logic [2:0] op;

   assign wacc = psel && penable && pwrite;
   assign issue = wacc && paddr == sbai_pkg::A_CMD;
   assign op = pwdata[sbai_pkg::F_OP_LSB +: 3];
   assign pready = 1'b1;

   // Register reads; unmapped addresses answer with an error.
   always_comb begin
      prdata = 32'h0000_0000;
      pslverr = 1'b0;
      case (paddr)
         sbai_pkg::A_CMD: prdata = 32'h0000_0000;
         sbai_pkg::A_WDATA: prdata[17:0] = wdata_q;
         sbai_pkg::A_RDATA: prdata[DW-1:0] = rdata_q;
         sbai_pkg::A_STAT: prdata[2:0] = {refused_q, rdone_q,
                                          st_q != sbai_pkg::CS_IDLE};
         sbai_pkg::A_CFG: prdata[1:0] = {cke_q, refen_q};
         default: pslverr = psel && penable;
      endcase
   end

   // Command sequencer; the link idles deselected with both masks high.
   always_comb begin
      st_d = st_q;
      cs_n_d = 1'b1;
      cmd_d = sbai_pkg::C_NOP;
      ba_d = ba_q;
      addr_d = addr_q;
      dq_d = dq_q;
      oe_d = 1'b0;
      mask_d = mask_q;
      wdata_d = wdata_q;
      rdata_d = rdata_q;
      rdone_d = rdone_q;
      refused_d = refused_q;
      refen_d = refen_q;
      cke_d = cke_q;
      bl_d = bl_q;
      sw_d = sw_q;
      cl3_d = cl3_q;
      left_d = left_q;
      cnt_d = cnt_q;
      tmr_d = tmr_q;
      due_d = due_q;
      if (wacc && paddr == sbai_pkg::A_WDATA) begin
         wdata_d = pwdata[17:0];
      end
      if (wacc && paddr == sbai_pkg::A_CFG) begin
         refen_d = pwdata[sbai_pkg::G_REFEN];
         cke_d = pwdata[sbai_pkg::G_CKE];
      end
      if (wacc && paddr == sbai_pkg::A_STAT) begin
         rdone_d = rdone_q && !pwdata[sbai_pkg::S_RDONE];
         refused_d = refused_q && !pwdata[sbai_pkg::S_REFUSED];
      end
      case (st_q)
         sbai_pkg::CS_IDLE: begin
            if (due_q && cke_q) begin
               // Refresh needs every bank closed, so close them first.
               st_d = sbai_pkg::CS_PRE;
               cs_n_d = 1'b0;
               cmd_d = sbai_pkg::C_PRE;
               addr_d = '0;
               addr_d[sbai_pkg::AP_BIT] = 1'b1;
               due_d = 1'b0;
            end else if (issue) begin
               st_d = sbai_pkg::CS_CMD;
               cs_n_d = 1'b0;
               cmd_d = op;
               ba_d = pwdata[sbai_pkg::F_BA_LSB +: 2];
               addr_d = pwdata[sbai_pkg::F_AD_LSB +: AW];
               if (op == sbai_pkg::C_RD || op == sbai_pkg::C_WR) begin
                  mask_d = {wdata_q[sbai_pkg::F_MH_BIT],
                            wdata_q[sbai_pkg::F_ML_BIT]};
               end
               if (op == sbai_pkg::C_WR) begin
                  oe_d = 1'b1;
                  dq_d = wdata_q[DW-1:0];
                  left_d = (sw_q ? 10'h001 : sbai_pkg::bl_beats(bl_q))
                           - 10'h001;
               end
               if (op == sbai_pkg::C_LMR &&
                   pwdata[sbai_pkg::F_BA_LSB +: 2] == 2'h0) begin
                  bl_d = pwdata[sbai_pkg::F_AD_LSB + sbai_pkg::MR_BL_LSB +: 3];
                  cl3_d = pwdata[sbai_pkg::F_AD_LSB + sbai_pkg::MR_CL_LSB
                          +: 3] == sbai_pkg::CL_3;
                  sw_d = pwdata[sbai_pkg::F_AD_LSB + sbai_pkg::MR_SW_BIT];
               end
            end
         end
         sbai_pkg::CS_CMD: begin
            if (cmd_q == sbai_pkg::C_WR && left_q != '0) begin
               st_d = sbai_pkg::CS_WR;
               oe_d = 1'b1;
               left_d = left_q - 10'h001;
            end else if (cmd_q == sbai_pkg::C_RD) begin
               st_d = sbai_pkg::CS_RD;
               cnt_d = cl3_q ? sbai_pkg::LAT3 : sbai_pkg::LAT2;
            end else begin
               st_d = sbai_pkg::CS_IDLE;
               mask_d = 2'h3;
            end
         end
         sbai_pkg::CS_WR: begin
            if (left_q == '0) begin
               st_d = sbai_pkg::CS_IDLE;
               mask_d = 2'h3;
            end else begin
               oe_d = 1'b1;
               left_d = left_q - 10'h001;
            end
         end
         sbai_pkg::CS_RD: begin
            if (cnt_q == 2'h1) begin
               rdata_d = link.dq;
               rdone_d = 1'b1;
               st_d = sbai_pkg::CS_IDLE;
               mask_d = 2'h3;
            end else begin
               cnt_d = cnt_q - 2'h1;
            end
         end
         sbai_pkg::CS_PRE: begin
            st_d = sbai_pkg::CS_REF;
            cs_n_d = 1'b0;
            cmd_d = sbai_pkg::C_REF;
         end
         default: st_d = sbai_pkg::CS_IDLE;
      endcase
      if (issue && (st_q != sbai_pkg::CS_IDLE || (due_q && cke_q))) begin
         refused_d = 1'b1;
      end
      // One refresh falls due every 3906 cycles (15.624 us) of enabled time.
      if (refen_q && cke_q) begin
         if (tmr_q == 12'(sbai_pkg::REF_IVL_CYC - 1)) begin
            tmr_d = 12'h000;
            due_d = 1'b1;
         end else begin
            tmr_d = tmr_q + 12'h001;
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_q <= sbai_pkg::CS_IDLE;
         cs_n_q <= 1'b1;
         cmd_q <= sbai_pkg::C_NOP;
         ba_q <= '0;
         addr_q <= '0;
         dq_q <= '0;
         oe_q <= 1'b0;
         mask_q <= 2'h3;
         wdata_q <= '0;
         rdata_q <= '0;
         rdone_q <= 1'b0;
         refused_q <= 1'b0;
         refen_q <= 1'b0;
         cke_q <= 1'b1;
         bl_q <= sbai_pkg::BL_1;
         sw_q <= 1'b0;
         cl3_q <= 1'b1;
         left_q <= '0;
         cnt_q <= 2'h0;
         tmr_q <= 12'h000;
         due_q <= 1'b0;
      end else begin
         st_q <= st_d;
         cs_n_q <= cs_n_d;
         cmd_q <= cmd_d;
         ba_q <= ba_d;
         addr_q <= addr_d;
         dq_q <= dq_d;
         oe_q <= oe_d;
         mask_q <= mask_d;
         wdata_q <= wdata_d;
         rdata_q <= rdata_d;
         rdone_q <= rdone_d;
         refused_q <= refused_d;
         refen_q <= refen_d;
         cke_q <= cke_d;
         bl_q <= bl_d;
         sw_q <= sw_d;
         cl3_q <= cl3_d;
         left_q <= left_d;
         cnt_q <= cnt_d;
         tmr_q <= tmr_d;
         due_q <= due_d;
      end
   end

   // Link pins come straight from registers.
   assign link.cke = cke_q;
   assign link.cs_n = cs_n_q;
   assign {link.ras_n, link.cas_n, link.we_n} = cmd_q;
   assign link.bank_select = ba_q;
   assign link.row_col_address = addr_q;
   assign link.low_byte_mask = mask_q[0];
   assign link.high_byte_mask = mask_q[1];
   assign link.ctl_dq = dq_q;
   assign link.ctl_dq_oe = oe_q;
endmodule

// File: verif/sbai_link_props.sv
module sbai_link_props (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic cke,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic [1:0] bank_select,
   input wire logic [11:0] row_col_address,
   input wire logic low_byte_mask,
   input wire logic high_byte_mask,
   input wire logic [15:0] ctl_dq,
   input wire logic ctl_dq_oe,
   input wire logic [1:0] mem_dq_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] cmd;
   logic take, pre_all, cl3, bwr;
   logic [11:0] mode_q, mode_d;
   // A command counts only on an edge that the device takes.
   assign cmd = {ras_n, cas_n, we_n};
   assign take = cke && !cs_n;
   assign pre_all = take && cmd == sbai_pkg::C_PRE && row_col_address[10];
   assign cl3 = mode_q[6:4] == sbai_pkg::CL_3;
   assign bwr = mode_q[2:0] != sbai_pkg::BL_1 && !mode_q[9];
   // Mode mirror, so that latency and burst figures are known here.
   always_comb begin
      mode_d = mode_q;
      if (take && cmd == sbai_pkg::C_LMR && bank_select == 2'h0) begin
         mode_d = row_col_address;
      end
   end
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mode_q <= 12'h030;
      end else begin
         mode_q <= mode_d;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   sequence rd_lo;
      take && cmd == sbai_pkg::C_RD && !low_byte_mask;
   endsequence
   sequence wr_go;
      take && cmd == sbai_pkg::C_WR;
   endsequence
   AST_RD_CL2: assert property (
      rd_lo ##0 !cl3 |-> ##2 mem_dq_oe[0])
      else $error("read data not out after two cycles");
   AST_RD_CL3: assert property (
      rd_lo ##0 cl3 |-> ##3 mem_dq_oe[0])
      else $error("read data not out after three cycles");
   AST_MASK_LO: assert property (
      $past(low_byte_mask, 2) |-> !mem_dq_oe[0])
      else $error("low lane driven while masked");
   AST_MASK_HI: assert property (
      $past(high_byte_mask, 2) |-> !mem_dq_oe[1])
      else $error("high lane driven while masked");
   AST_WR_OE: assert property (wr_go |-> ctl_dq_oe)
      else $error("write data absent at command");
   AST_WR_HOLD: assert property (
      wr_go ##0 bwr |=> ctl_dq_oe && $stable(ctl_dq) &&
      $stable(low_byte_mask))
      else $error("write data not held for burst");
   AST_WR_ONE: assert property (wr_go ##0 !bwr |=> !ctl_dq_oe)
      else $error("single write drove more beats");
   AST_REF_PRE: assert property (
      take && cmd == sbai_pkg::C_REF |-> $past(pre_all))
      else $error("refresh without close of all banks");
endmodule

// File: verif/tb_sdram_bank_access_interface.sv
module tb_sdram_bank_access_interface;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, r;
   logic pready, pslverr, slv;
   int errors = 0;
   int checked = 0;
   sbai_link_if link ();
   sbai_ctrl sbai_ctrl_inst (.clk(clk), .arst_n(arst_n), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link.ctrl));
   sbai_dram sbai_dram_inst (.clk(clk), .arst_n(arst_n), .link(link.mem));
   sbai_link_props sbai_link_props_inst (.clk(clk), .arst_n(arst_n),
      .cke(link.cke), .cs_n(link.cs_n), .ras_n(link.ras_n),
      .cas_n(link.cas_n), .we_n(link.we_n), .bank_select(link.bank_select),
      .row_col_address(link.row_col_address), .ctl_dq(link.ctl_dq),
      .low_byte_mask(link.low_byte_mask), .ctl_dq_oe(link.ctl_dq_oe),
      .high_byte_mask(link.high_byte_mask), .mem_dq_oe(link.mem_dq_oe));
   // The clock toggles every half period.
   always #2 clk = ~clk;
   task automatic summarize();
      if (errors == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] e, input logic [31:0] s, string n);
      checked++;
      if (s !== e) begin
         errors++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask
   // One bus transfer; a spare cycle after it keeps each strobe edge unique.
   task automatic apb(input logic w, input logic [7:0] a, logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      slv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic cmd(input logic [2:0] op, logic [1:0] ba, logic [11:0] ad);
      apb(1, sbai_pkg::A_CMD, {15'h0, ad, ba, op});
   endtask
   // Polling has no bound of its own; the watchdog ends a hang.
   task automatic idle();
      do apb(0, sbai_pkg::A_STAT, 0); while (r[0] !== 1'b0);
   endtask
   task automatic rd_word(input logic [11:0] col, input logic [15:0] e);
      cmd(sbai_pkg::C_RD, 1, col);
      idle();
      apb(0, sbai_pkg::A_RDATA, 0);
      chk({16'h0, e}, r & 32'hffff, "read word");
   endtask
   initial begin
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      apb(0, sbai_pkg::A_CFG, 0);
      chk(32'h2, r & 32'h3, "cfg");
      cmd(sbai_pkg::C_LMR, 0, 12'h221);
      cmd(sbai_pkg::C_ACT, 1, 12'h005);
      apb(1, sbai_pkg::A_WDATA, 32'hbeef);
      cmd(sbai_pkg::C_WR, 1, 12'h004);
      idle();
      rd_word(12'h004, 16'hbeef);
      apb(0, sbai_pkg::A_STAT, 0);
      chk(32'h2, r & 32'h7, "stat");
      apb(1, sbai_pkg::A_STAT, 32'h2);
      rd_word(12'h005, 16'h0000);
      cmd(sbai_pkg::C_LMR, 0, 12'h033);
      apb(1, sbai_pkg::A_WDATA, 32'h21234);
      cmd(sbai_pkg::C_WR, 1, 12'h004);
      cmd(sbai_pkg::C_RD, 1, 12'h004);
      idle();
      apb(0, sbai_pkg::A_STAT, 0);
      chk(32'h4, r & 32'h4, "refused");
      apb(1, sbai_pkg::A_WDATA, 32'h0);
      rd_word(12'h004, 16'hbe34);
      rd_word(12'h006, 16'h0034);
      apb(1, sbai_pkg::A_WDATA, 32'h20000);
      rd_word(12'h004, 16'h0034);
      apb(0, 8'h20, 0);
      chk(32'h1, {31'h0, slv}, "pslverr");
      rd_word(12'h404, 16'h0034);
      apb(1, sbai_pkg::A_WDATA, 32'h5555);
      cmd(sbai_pkg::C_WR, 1, 12'h007);
      idle();
      cmd(sbai_pkg::C_ACT, 1, 12'h005);
      rd_word(12'h007, 16'h0034);
      cmd(sbai_pkg::C_LMR, 2, 12'h002);
      apb(1, sbai_pkg::A_CFG, 32'h0);
      cmd(sbai_pkg::C_REF, 0, 12'h000);
      repeat (40) @(posedge clk);
      apb(1, sbai_pkg::A_CFG, 32'h2);
      rd_word(12'h006, 16'h0000);
      apb(1, sbai_pkg::A_CFG, 32'h3);
      repeat (4000) @(posedge clk);
      summarize();
   end
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      summarize();
   end
endmodule
